// file: verilog/rspc_pkg.sv
// Constants for the reset strap and pull-up control block
`default_nettype none
package rspc_pkg;
  localparam logic [7:0] RSPC_PULLUP_CTL_IDX   = 8'h3F;
  localparam logic [7:0] RSPC_PULLUP_CTL_RESET = 8'h00;
  localparam int         RSPC_BIT_SENSE_OFF    = 5;
  localparam int         RSPC_BIT_MEM_PULLUP   = 4;
  localparam int         RSPC_BIT_IO_PULLUP    = 3;
  localparam logic [9:0] RSPC_PORT_INDEX_PRI   = 10'h3E0;
  localparam logic [9:0] RSPC_PORT_DATA_PRI    = 10'h3E1;
  localparam logic [9:0] RSPC_PORT_INDEX_SEC   = 10'h3E2;
  localparam logic [9:0] RSPC_PORT_DATA_SEC    = 10'h3E3;
  localparam int         RSPC_SLOT_MSB         = 7;
  localparam int         RSPC_SLOT_LSB         = 6;
  localparam int         RSPC_REG_IDX_MSB      = 5;

  typedef enum logic [1:0] {
    RSPC_TEST_NAND    = 2'b00,
    RSPC_TEST_HILO    = 2'b01,
    RSPC_TEST_LOHI    = 2'b10,
    RSPC_TEST_TRISTATE = 2'b11
  } rspc_test_fn_t;
endpackage
`default_nettype wire

// file: verilog/rspc_strap_if.sv
// Captured strap values passed from latch to control logic
`default_nettype none
interface rspc_strap_if;
  import rspc_pkg::*;
  logic          [1:0] slot_sel;
  logic                secondary;
  logic                test_mode;
  rspc_test_fn_t       test_fn;
  modport source (output slot_sel, output secondary, output test_mode, output test_fn);
  modport sink   (input slot_sel, input secondary, input test_mode, input test_fn);
endinterface
`default_nettype wire

// file: verilog/rspc_strap_latch.sv
// Strap sampling at the release of the host reset drive
`default_nettype none
module rspc_strap_latch
  import rspc_pkg::*;
(
  input  wire logic   sys_clk_i,
  input  wire logic   srst_i,
  input  wire logic   rst_drive_i,
  input  wire logic   prog_sel_s_i,
  input  wire logic   prog_follow_s_i,
  input  wire logic   supply_5v_s_i,
  input  wire logic   supply_3v3_s_i,
  rspc_strap_if.source straps
);
  logic rst_drive_d_r;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rst_drive_d_r <= 1'b1;
    end else begin
      rst_drive_d_r <= rst_drive_i;
    end
  end

  // Captured on every falling edge of reset drive, frozen in between
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      straps.slot_sel  <= 2'b00;
      straps.secondary <= 1'b0;
      straps.test_mode <= 1'b0;
      straps.test_fn   <= RSPC_TEST_NAND;
    end else if (rst_drive_d_r && !rst_drive_i) begin
      straps.slot_sel  <= {~prog_follow_s_i, ~prog_sel_s_i};
      straps.secondary <= supply_5v_s_i;
      straps.test_mode <= supply_3v3_s_i;
      straps.test_fn   <= rspc_test_fn_t'({~prog_follow_s_i, ~prog_sel_s_i});
    end
  end

  // Every captured field, not only the port pair, must stay frozen
  chk_capture_edge : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(rst_drive_d_r && !rst_drive_i)
    |=> $stable({straps.slot_sel, straps.secondary, straps.test_mode, straps.test_fn}))
    else $error("strap changed outside capture edge");
endmodule
`default_nettype wire

// file: verilog/rspc_top.sv
// Reset strap capture, index decode and slot pull-up control
`default_nettype none
module rspc_top
  import rspc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       host_reset_drive_i,
  input  wire logic       prog_voltage_select_i,
  input  wire logic       prog_voltage_follow_supply_i,
  input  wire logic       card_supply_5v_ctl_i,
  input  wire logic       card_supply_3v3_ctl_i,
  input  wire logic       prog_voltage_select_req_i,
  input  wire logic       prog_voltage_follow_supply_req_i,
  input  wire logic       card_supply_5v_req_i,
  input  wire logic       card_supply_3v3_req_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [9:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic            prog_voltage_select_o,
  output logic            prog_voltage_select_oe_o,
  output logic            prog_voltage_follow_supply_o,
  output logic            prog_voltage_follow_supply_oe_o,
  output logic            card_supply_5v_ctl_o,
  output logic            card_supply_5v_ctl_oe_o,
  output logic            card_supply_3v3_ctl_o,
  output logic            card_supply_3v3_ctl_oe_o,
  output logic            prog_pins_pullup_en_o,
  output logic            card_present_pullup_en_o,
  output logic            supply_sense_pullup_en_o,
  output logic            battery_ready_pullup_en_o,
  output logic            input_ack_wait_pullup_en_o,
  output logic            device_sel_o,
  output logic [7:0]      index_o,
  output logic            test_mode_o,
  output logic [1:0]      test_fn_o,
  output logic [7:0]      pullup_ctl_rdata_o
);
  rspc_strap_if straps();

  logic       host_reset_drive_m_r;
  logic       host_reset_drive_s_r;
  logic [3:0] pins_m_r;
  logic [3:0] pins_s_r;
  logic [7:0] index_r;
  logic [7:0] pullup_ctl_r;
  logic       sel_nxt;

  function automatic logic is_port(input logic [9:0] a, input logic sec,
                                   input logic [9:0] pri_p, input logic [9:0] sec_p);
    is_port = sec ? (a == sec_p) : (a == pri_p);
  endfunction

  // Pins are asynchronous; two stages before any use
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      host_reset_drive_m_r <= 1'b1;
      host_reset_drive_s_r <= 1'b1;
      pins_m_r   <= 4'h0;
      pins_s_r   <= 4'h0;
    end else begin
      host_reset_drive_m_r <= host_reset_drive_i;
      host_reset_drive_s_r <= host_reset_drive_m_r;
      pins_m_r   <= {card_supply_3v3_ctl_i, card_supply_5v_ctl_i,
                     prog_voltage_follow_supply_i, prog_voltage_select_i};
      pins_s_r   <= pins_m_r;
    end
  end

  rspc_strap_latch u_latch (
    .sys_clk_i       (sys_clk_i),
    .srst_i          (srst_i),
    .rst_drive_i     (host_reset_drive_s_r),
    .prog_sel_s_i    (pins_s_r[0]),
    .prog_follow_s_i (pins_s_r[1]),
    .supply_5v_s_i   (pins_s_r[2]),
    .supply_3v3_s_i  (pins_s_r[3]),
    .straps          (straps.source)
  );

  // Power pins during reset drive; released to requests afterwards
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || host_reset_drive_s_r) begin
      prog_voltage_select_o           <= 1'b1;
      prog_voltage_follow_supply_o    <= 1'b1;
      prog_voltage_select_oe_o        <= 1'b1;
      prog_voltage_follow_supply_oe_o <= 1'b1;
      card_supply_5v_ctl_o            <= 1'b0;
      card_supply_3v3_ctl_o           <= 1'b0;
      // Not driven so the board straps can be read
      card_supply_5v_ctl_oe_o         <= 1'b0;
      card_supply_3v3_ctl_oe_o        <= 1'b0;
      prog_pins_pullup_en_o           <= 1'b1;
    end else begin
      prog_voltage_select_o           <= prog_voltage_select_req_i;
      prog_voltage_follow_supply_o    <= prog_voltage_follow_supply_req_i;
      prog_voltage_select_oe_o        <= 1'b1;
      prog_voltage_follow_supply_oe_o <= 1'b1;
      card_supply_5v_ctl_o            <= card_supply_5v_req_i;
      card_supply_3v3_ctl_o           <= card_supply_3v3_req_i;
      card_supply_5v_ctl_oe_o         <= 1'b1;
      card_supply_3v3_ctl_oe_o        <= 1'b1;
      prog_pins_pullup_en_o           <= 1'b0;
    end
  end

  // Index tracking; every chip latches index writes on its port pair
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      index_r <= 8'h00;
    end else if (io_wr_i && is_port(io_addr_i, straps.secondary,
                                    RSPC_PORT_INDEX_PRI, RSPC_PORT_INDEX_SEC)) begin
      index_r <= io_wdata_i;
    end
  end

  always_comb begin
    sel_nxt = (io_wr_i || io_rd_i)
           && is_port(io_addr_i, straps.secondary, RSPC_PORT_DATA_PRI, RSPC_PORT_DATA_SEC)
           && (index_r[RSPC_SLOT_MSB:RSPC_SLOT_LSB] == straps.slot_sel);
  end

  // Control register at local index 3F within our slot range
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pullup_ctl_r <= RSPC_PULLUP_CTL_RESET;
    end else if (sel_nxt && io_wr_i
                 && index_r[RSPC_REG_IDX_MSB:0] == RSPC_PULLUP_CTL_IDX[RSPC_REG_IDX_MSB:0]) begin
      pullup_ctl_r <= io_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      device_sel_o               <= 1'b0;
      index_o                    <= 8'h00;
      test_mode_o                <= 1'b0;
      test_fn_o                  <= 2'b00;
      pullup_ctl_rdata_o         <= RSPC_PULLUP_CTL_RESET;
      card_present_pullup_en_o   <= 1'b1;
      supply_sense_pullup_en_o   <= 1'b1;
      battery_ready_pullup_en_o  <= 1'b0;
      input_ack_wait_pullup_en_o <= 1'b0;
    end else begin
      device_sel_o               <= sel_nxt;
      index_o                    <= index_r;
      test_mode_o                <= straps.test_mode;
      test_fn_o                  <= straps.test_mode ? straps.test_fn : 2'b00;
      pullup_ctl_rdata_o         <= pullup_ctl_r;
      card_present_pullup_en_o   <= !pullup_ctl_r[RSPC_BIT_SENSE_OFF];
      supply_sense_pullup_en_o   <= !pullup_ctl_r[RSPC_BIT_SENSE_OFF];
      battery_ready_pullup_en_o  <= pullup_ctl_r[RSPC_BIT_MEM_PULLUP];
      input_ack_wait_pullup_en_o <= pullup_ctl_r[RSPC_BIT_IO_PULLUP];
    end
  end

  // Claimed write to the control register
  sequence s_ctl_write;
    sel_nxt && io_wr_i && index_r[RSPC_REG_IDX_MSB:0] == RSPC_PULLUP_CTL_IDX[RSPC_REG_IDX_MSB:0];
  endsequence
  // Reset drive seen, then released
  sequence s_drive_release;
    host_reset_drive_s_r ##1 !host_reset_drive_s_r;
  endsequence

  chk_sense_pullup_off : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    pullup_ctl_r[RSPC_BIT_SENSE_OFF] |=> !card_present_pullup_en_o && !supply_sense_pullup_en_o)
    else $error("sense pull-ups not disabled");
  chk_sense_default : assert property (@(posedge sys_clk_i)
    $fell(srst_i) |-> card_present_pullup_en_o && supply_sense_pullup_en_o)
    else $error("sense pull-ups not on after reset");
  chk_mem_pullup : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(pullup_ctl_r[RSPC_BIT_MEM_PULLUP]) |=> battery_ready_pullup_en_o)
    else $error("memory pull-ups not following bit 4");
  chk_io_pullup : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(pullup_ctl_r[RSPC_BIT_IO_PULLUP]) |=> input_ack_wait_pullup_en_o)
    else $error("io pull-ups not following bit 3");
  chk_prog_pullup : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !host_reset_drive_s_r |=> !prog_pins_pullup_en_o)
    else $error("programming pull-ups left on");
  chk_reset_drive : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    host_reset_drive_s_r |=> prog_voltage_select_o && prog_voltage_follow_supply_o
                   && !card_supply_5v_ctl_o && !card_supply_3v3_ctl_o)
    else $error("power pins wrong during reset drive");
  chk_sel_range : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    device_sel_o |-> $past(index_r[RSPC_SLOT_MSB:RSPC_SLOT_LSB]) == $past(straps.slot_sel))
    else $error("select outside slot range");
  chk_test_mode : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !straps.test_mode |=> test_fn_o == 2'b00)
    else $error("test function set outside test mode");
  chk_ctl_write : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_ctl_write |=> pullup_ctl_r == $past(io_wdata_i))
    else $error("control register write lost");
  chk_ctl_hold : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(sel_nxt && io_wr_i) |=> $stable(pullup_ctl_r))
    else $error("control register changed without a claimed write");
  // Index port of the other pair must not disturb the latched index
  chk_index_pair : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(io_wr_i && is_port(io_addr_i, straps.secondary, RSPC_PORT_INDEX_PRI, RSPC_PORT_INDEX_SEC))
    |=> $stable(index_r))
    else $error("index latched from the wrong port");
  chk_sel_access : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    device_sel_o |-> $past(io_wr_i || io_rd_i))
    else $error("select without an access");
  chk_drive_release : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_drive_release |=> card_supply_5v_ctl_oe_o && card_supply_3v3_ctl_oe_o && !prog_pins_pullup_en_o)
    else $error("power pins not released after reset drive");
endmodule
`default_nettype wire

// file: verilog/dummy_unused_placeholder_none.sv
// Intentionally empty design file
`default_nettype none
`default_nettype wire

// file: tb/rspc_board_model.sv
// Board straps, power switch and pin levels seen by the device
`default_nettype none
module rspc_board_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] strap_i,
  input  wire logic [3:0] pin_drv_i,
  input  wire logic [3:0] pin_oe_i,
  input  wire logic       pullup_en_i,
  output logic      [3:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Order {3v3 high, 5v high, follow low, select low}
  logic toggle_r = 1'b0;
  always @(posedge clk_i) begin
    toggle_r <= ~toggle_r;
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Reset-time high drive is weak, a pull-down strap wins
      if (pin_oe_i[i] && !pullup_en_i) pin_lvl_o[i] = pin_drv_i[i];
      else if (strap_i[i]) pin_lvl_o[i] = 1'b0;
      else if (pullup_en_i) pin_lvl_o[i] = 1'b1;
      else pin_lvl_o[i] = toggle_r;
    end
    for (int i = 2; i < 4; i++) begin
      // Board pull-up or pull-down when undriven
      if (pin_oe_i[i]) pin_lvl_o[i] = pin_drv_i[i];
      else pin_lvl_o[i] = strap_i[i];
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for strap capture, claiming and pull-up control
`default_nettype none
module testbench
  import rspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, host_reset_drive_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic prog_voltage_select_req_i = 1'b0, prog_voltage_follow_supply_req_i = 1'b0;
  logic card_supply_5v_req_i = 1'b1, card_supply_3v3_req_i = 1'b1;
  logic [9:0] io_addr_i = 10'h000;
  logic [7:0] io_wdata_i = 8'h00;
  logic [3:0] strap = 4'h0;
  wire logic [3:0] pins;
  wire logic prog_voltage_select_i, prog_voltage_follow_supply_i, card_supply_5v_ctl_i, card_supply_3v3_ctl_i;
  logic prog_voltage_select_o, prog_voltage_select_oe_o, prog_voltage_follow_supply_o;
  logic prog_voltage_follow_supply_oe_o, card_supply_5v_ctl_o, card_supply_5v_ctl_oe_o;
  logic card_supply_3v3_ctl_o, card_supply_3v3_ctl_oe_o, prog_pins_pullup_en_o, card_present_pullup_en_o;
  logic supply_sense_pullup_en_o, battery_ready_pullup_en_o, input_ack_wait_pullup_en_o, device_sel_o;
  logic test_mode_o;
  logic [7:0] index_o, pullup_ctl_rdata_o;
  logic [1:0] test_fn_o;
  int n_mismatch = 0;
  int total_checks = 0;
  assign prog_voltage_select_i = pins[0];
  assign prog_voltage_follow_supply_i = pins[1];
  assign card_supply_5v_ctl_i = pins[2];
  assign card_supply_3v3_ctl_i = pins[3];
  always #4 sys_clk_i = ~sys_clk_i;
  rspc_top i_rspc_top (.*);
  rspc_board_model i_rspc_board_model (
    .clk_i       (sys_clk_i),
    .strap_i     (strap),
    .pin_drv_i   ({card_supply_3v3_ctl_o, card_supply_5v_ctl_o, prog_voltage_follow_supply_o, prog_voltage_select_o}),
    .pin_oe_i    ({card_supply_3v3_ctl_oe_o, card_supply_5v_ctl_oe_o, prog_voltage_follow_supply_oe_o,
                   prog_voltage_select_oe_o}),
    .pullup_en_i (prog_pins_pullup_en_o),
    .pin_lvl_o   (pins)
  );
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One port access; an idle edge first keeps drives one per time step
  task automatic io(input logic wr, input logic [9:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    #1;
    io_wr_i = wr;
    io_rd_i = ~wr;
    io_addr_i = addr;
    io_wdata_i = data;
    @(posedge sys_clk_i);
    #1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask
  task automatic boot(input logic [3:0] s);
    strap = s;
    host_reset_drive_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("prog drive", 8'h03, {prog_voltage_select_o, prog_voltage_follow_supply_o});
    chk("supply low", 8'h00, {card_supply_5v_ctl_o, card_supply_3v3_ctl_o});
    chk("prog pullup", 8'h01, prog_pins_pullup_en_o);
    chk("drive oe", 8'h0C, {prog_voltage_select_oe_o, prog_voltage_follow_supply_oe_o,
        card_supply_5v_ctl_oe_o, card_supply_3v3_ctl_oe_o});
    host_reset_drive_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk("prog pullup off", 8'h00, prog_pins_pullup_en_o);
    chk("released", 8'h3F, {prog_voltage_select_o, prog_voltage_follow_supply_o, card_supply_5v_ctl_o,
        card_supply_3v3_ctl_o, prog_voltage_select_oe_o, prog_voltage_follow_supply_oe_o,
        card_supply_5v_ctl_oe_o, card_supply_3v3_ctl_oe_o});
    chk("test mode", s[3], test_mode_o);
    chk("test fn", s[3] ? s[1:0] : 2'b00, test_fn_o);
  endtask
  task automatic claim(input logic [2:0] s);
    logic [9:0] ip, dp;
    logic [7:0] own;
    ip = s[2] ? RSPC_PORT_INDEX_SEC : RSPC_PORT_INDEX_PRI;
    dp = s[2] ? RSPC_PORT_DATA_SEC : RSPC_PORT_DATA_PRI;
    own = {s[1:0], 6'h15};
    io(1'b1, ip, own);
    // Index output lags the latched index by one edge
    @(posedge sys_clk_i);
    #1;
    chk("index", own, index_o);
    io(1'b0, dp, 8'h00);
    chk("sel own", 8'h01, device_sel_o);
    io(1'b1, ip, own + 8'h40);
    io(1'b1, dp, 8'h00);
    chk("sel other", 8'h00, device_sel_o);
    io(1'b1, ip ^ 10'h002, own);
    chk("index kept", own + 8'h40, index_o);
    io(1'b1, ip, own);
    io(1'b0, dp ^ 10'h002, 8'h00);
    chk("sel pair", 8'h00, device_sel_o);
    strap = ~strap;
    io(1'b1, ip, own);
    io(1'b0, dp, 8'h00);
    chk("sel hold", 8'h01, device_sel_o);
  endtask
  task automatic regs();
    logic [7:0] v;
    boot(4'h5);
    chk("card pullup", 8'h01, card_present_pullup_en_o);
    chk("sense pullup", 8'h01, supply_sense_pullup_en_o);
    chk("ctl reset", RSPC_PULLUP_CTL_RESET, pullup_ctl_rdata_o);
    for (int b = 3; b < 6; b++) begin
      v = 8'h01 << b;
      io(1'b1, RSPC_PORT_INDEX_SEC, 8'h7F);
      io(1'b1, RSPC_PORT_DATA_SEC, v);
      // Read-back output lags the register by one edge
      @(posedge sys_clk_i);
      #1;
      chk("ctl data", v, pullup_ctl_rdata_o);
      io(1'b1, RSPC_PORT_INDEX_SEC, 8'h3F);
      io(1'b1, RSPC_PORT_DATA_SEC, 8'hFF);
      chk("ctl other slot", v, pullup_ctl_rdata_o);
      chk("pullups", {4'h0, ~v[5], ~v[5], v[4], v[3]}, {4'h0, card_present_pullup_en_o,
          supply_sense_pullup_en_o, battery_ready_pullup_en_o, input_ack_wait_pullup_en_o});
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    for (int c = 0; c < 16; c++) begin
      boot(c[3:0]);
      if (!c[3]) claim(c[2:0]);
    end
    regs();
    final_report();
  end
endmodule
`default_nettype wire
